//--- design/unc_pkg.sv
// Package for the ninth-bit, line and error interrupt control block
package unc_pkg;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // Register indices as printed; byte address is four times the index
  localparam logic [AXI_AW-1:0] C3_INDEX   = 8'h06;
  localparam logic [AXI_AW-1:0] DATA_INDEX = 8'h07;
  localparam logic [AXI_AW-1:0] C3_ADDR    = 8'h18;
  localparam logic [AXI_AW-1:0] DATA_ADDR  = 8'h1C;
  localparam logic [AXI_AW-1:0] LINE_ADDR  = 8'h20;
  localparam logic [AXI_AW-1:0] STAT_ADDR  = 8'h24;
  localparam logic [AXI_AW-1:0] MASK_ADDR  = 8'h28;

  // Fields of ninth_bit_line_irq_control
  localparam int C3_RX_NINTH  = 7;
  localparam int C3_TX_NINTH  = 6;
  localparam int C3_OUT_DIR   = 5;
  localparam int C3_POL_FLIP  = 4;
  localparam int C3_OVR_EN    = 3;
  localparam int C3_NOISE_EN  = 2;
  localparam int C3_FRAME_EN  = 1;
  localparam int C3_PARITY_EN = 0;

  // Fields of the line select register
  localparam int LINE_NINE_BIT = 0;
  localparam int LINE_LOOP     = 1;
  localparam int LINE_RX_SRC   = 2;

  // Error flag layout, shared by status, mask and enables
  localparam int ERR_PARITY = 0;
  localparam int ERR_FRAME  = 1;
  localparam int ERR_NOISE  = 2;
  localparam int ERR_OVR    = 3;

  localparam logic [6:0] C3_RESET   = 7'h00;
  localparam logic [2:0] LINE_RESET = 3'h0;
  localparam logic [3:0] MASK_RESET = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [AXI_DW-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } unc_axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              arready;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
  } unc_axil_rsp_t;

  typedef struct packed {
    logic       overrun;
    logic       noise;
    logic       framing;
    logic       parity;
  } unc_err_t;

endpackage

//--- design/unc_ctrl.sv
// Ninth-bit, line control and error interrupt block of a serial transceiver
// Overview of operation
// - In 9-bit mode the received ninth bit reads as bit 7 above the data byte.
// - In 9-bit mode bit 6 is the ninth transmit bit above the byte.
// - A data write sends all nine bits; the ninth bit holds until rewritten.
// - In single-wire mode bit 5 sets pin direction: 0 input, 1 output.
// - Bit 4 inverts every transmitted level, idle and break included.
// - Bit 3 enables an interrupt while the overrun flag is set.
// - Bit 2 enables an interrupt while the noise flag is set.
// - Bit 1 enables an interrupt while the framing flag is set.
// - Bit 0 enables an interrupt while the parity flag is set.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module unc_ctrl
  import unc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire unc_axil_req_t axi_req,
  output unc_axil_rsp_t      axi_rsp,
  input  wire logic          rx_word_valid,
  input  wire logic [8:0]    rx_word,
  input  wire unc_err_t      rx_err_event,
  input  wire logic          tx_word_ready,
  output logic               tx_word_valid,
  output logic [8:0]         tx_word,
  output logic               nine_bit_select,
  input  wire logic          tx_shift_level,
  output logic               txd_pin_o,
  output logic               txd_pin_oe,
  input  wire logic          txd_pin_i,
  input  wire logic          rxd_pin_i,
  output logic               rx_line,
  output logic               irq
);

  function automatic logic [3:0] err_vec(input unc_err_t e);
    err_vec = {e.overrun, e.noise, e.framing, e.parity};
  endfunction

  // Register select; every register owns one aligned word
  function automatic logic reg_hit(input logic              fire,
                                   input logic [AXI_AW-1:0] addr,
                                   input logic [AXI_AW-1:0] reg_addr);
    reg_hit = fire && (addr == reg_addr);
  endfunction

  // AXI4-Lite state
  logic              aw_held_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic              w_held_q;
  logic [AXI_DW-1:0] w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [AXI_DW-1:0] rdata_q;
  logic [1:0]        rresp_q;

  // Register state
  logic [6:0]        c3_q;
  logic [2:0]        line_q;
  logic [3:0]        status_q;
  logic [3:0]        mask_q;
  logic [7:0]        rx_byte_q;
  logic              rx_ninth_bit_q;
  logic              rx_full_q;
  logic [8:0]        tx_word_q;
  logic              tx_valid_q;
  logic              txd_o_q;
  logic              txd_oe_q;
  logic              rx_line_q;

  logic              wr_fire;
  logic              wr_ok;
  logic              wr_lane0;
  logic              rd_fire;
  logic              rd_data_hit;
  logic [3:0]        err_en;
  logic [3:0]        err_set;
  logic [3:0]        stat_clr;
  logic              single_wire;
  logic              loop_only;
  logic              wr_go;
  logic              c3_wr;
  logic              line_wr;
  logic              mask_wr;
  logic              stat_wr;
  logic              data_wr;

  assign wr_fire  = aw_held_q && w_held_q && !bvalid_q;
  assign wr_lane0 = w_strb_q[0];
  assign rd_fire  = axi_req.arvalid && !rvalid_q;

  // Lane 0 carries every field; a write without it is answered but dropped
  assign wr_go    = wr_fire && wr_lane0;
  assign c3_wr    = reg_hit(wr_go, aw_addr_q, C3_ADDR);
  assign line_wr  = reg_hit(wr_go, aw_addr_q, LINE_ADDR);
  assign mask_wr  = reg_hit(wr_go, aw_addr_q, MASK_ADDR);
  assign stat_wr  = reg_hit(wr_go, aw_addr_q, STAT_ADDR);
  assign data_wr  = reg_hit(wr_go, aw_addr_q, DATA_ADDR);

  always_comb begin
    unique case (aw_addr_q)
      C3_ADDR, DATA_ADDR, LINE_ADDR, STAT_ADDR, MASK_ADDR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write channels taken in either order, response after both
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (axi_req.awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= axi_req.awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (axi_req.wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= axi_req.wdata;
      w_strb_q <= axi_req.wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read path; unmapped addresses answer SLVERR with zero data
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      unique case (axi_req.araddr)
        C3_ADDR:   rdata_q <= {24'h00_0000, rx_ninth_bit_q, c3_q[C3_TX_NINTH:0]};
        DATA_ADDR: rdata_q <= {24'h00_0000, rx_byte_q};
        LINE_ADDR: rdata_q <= {29'h0000_0000, line_q};
        STAT_ADDR: rdata_q <= {27'h000_0000, rx_full_q, status_q};
        MASK_ADDR: rdata_q <= {28'h000_0000, mask_q};
        default: begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign axi_rsp.awready = !aw_held_q;
  assign axi_rsp.wready  = !w_held_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rdata   = rdata_q;
  assign axi_rsp.rresp   = rresp_q;

  // Control register and line selects
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      c3_q <= C3_RESET;
    end else if (c3_wr) begin
      c3_q <= w_data_q[6:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      line_q <= LINE_RESET;
    end else if (line_wr) begin
      line_q <= w_data_q[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mask_q <= MASK_RESET;
    end else if (mask_wr) begin
      mask_q <= w_data_q[3:0];
    end
  end

  assign nine_bit_select = line_q[LINE_NINE_BIT];

  // Receive buffer; a data read frees it, so the ninth bit must be read first
  assign rd_data_hit = reg_hit(rd_fire, axi_req.araddr, DATA_ADDR);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_byte_q      <= '0;
      rx_ninth_bit_q <= 1'b0;
    end else if (rx_word_valid && (!rx_full_q || rd_data_hit)) begin
      rx_byte_q      <= rx_word[7:0];
      rx_ninth_bit_q <= nine_bit_select & rx_word[8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_full_q <= 1'b0;
    end else if (rx_word_valid) begin
      rx_full_q <= 1'b1;
    end else if (rd_data_hit) begin
      rx_full_q <= 1'b0;
    end
  end

  // Sticky error flags; a new event beats a clear in the same cycle
  always_comb begin
    err_set = err_vec(rx_err_event);
    err_set[ERR_OVR] = err_set[ERR_OVR] | (rx_word_valid & rx_full_q & !rd_data_hit);
  end

  assign stat_clr = stat_wr ? w_data_q[3:0] : 4'h0;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~stat_clr) | err_set;
    end
  end

  // Enables in the same layout as the flags
  always_comb begin
    err_en = '0;
    err_en[ERR_OVR]    = c3_q[C3_OVR_EN];
    err_en[ERR_NOISE]  = c3_q[C3_NOISE_EN];
    err_en[ERR_FRAME]  = c3_q[C3_FRAME_EN];
    err_en[ERR_PARITY] = c3_q[C3_PARITY_EN];
  end

  // Mask defaults open so the enables alone decide after reset
  assign irq = |(status_q & err_en & mask_q);

  // Transmit hand-off; a write while pending replaces the waiting word
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_word_q  <= '0;
      tx_valid_q <= 1'b0;
    end else if (data_wr) begin
      tx_word_q  <= {nine_bit_select & c3_q[C3_TX_NINTH], w_data_q[7:0]};
      tx_valid_q <= 1'b1;
    end else if (tx_word_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  assign tx_word_valid = tx_valid_q;
  assign tx_word       = tx_word_q;

  // Pin side
  assign single_wire = line_q[LINE_LOOP] & line_q[LINE_RX_SRC];
  assign loop_only   = line_q[LINE_LOOP] & !line_q[LINE_RX_SRC];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      txd_o_q  <= 1'b1;
      txd_oe_q <= 1'b1;
    end else begin
      txd_o_q  <= tx_shift_level ^ c3_q[C3_POL_FLIP];
      txd_oe_q <= single_wire ? c3_q[C3_OUT_DIR] : 1'b1;
    end
  end

  // Receiver source: own pin, internal loop, or the shared pin
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_line_q <= 1'b1;
    end else if (single_wire) begin
      rx_line_q <= txd_pin_i;
    end else if (loop_only) begin
      rx_line_q <= tx_shift_level;
    end else begin
      rx_line_q <= rxd_pin_i;
    end
  end

  assign txd_pin_o  = txd_o_q;
  assign txd_pin_oe = txd_oe_q;
  assign rx_line    = rx_line_q;

endmodule

//--- tb/unc_ctrl_asserts.sv
// Assertion checker for the ninth-bit, line and error interrupt block
`timescale 1ns/1ps
module unc_ctrl_asserts
  import unc_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          nrst,
  input wire unc_axil_req_t axi_req,
  input wire unc_axil_rsp_t axi_rsp,
  input wire logic          rx_word_valid,
  input wire unc_err_t      rx_err_event,
  input wire logic          tx_word_ready,
  input wire logic          tx_word_valid,
  input wire logic          tx_shift_level,
  input wire logic          txd_pin_o,
  input wire logic          txd_pin_oe,
  input wire logic          txd_pin_i,
  input wire logic          rx_line,
  input wire logic          irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_wtake; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready; endsequence
  property p_wr; s_wtake |=> !axi_rsp.awready ##1 axi_rsp.bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer not two cycles after take");
  property p_b; axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp); endproperty
  a_b: assert property (p_b) else $error("write response dropped early");
  property p_ar; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready; endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  property p_r; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata); endproperty
  a_r: assert property (p_r) else $error("read data dropped early");
  property p_tx; tx_word_valid && !tx_word_ready |=> tx_word_valid; endproperty
  a_tx: assert property (p_tx) else $error("transmit word lost");
  property p_pol; $changed(tx_shift_level) |=> $changed(txd_pin_o); endproperty
  a_pol: assert property (p_pol) else $error("pin did not follow line level");
  property p_sw; !txd_pin_oe |-> rx_line == $past(txd_pin_i); endproperty
  a_sw: assert property (p_sw) else $error("shared wire not received");
  // Irq may only rise after an event or a register write
  property p_irq; $rose(irq) |-> ($past(rx_err_event) != 4'h0) || $past(rx_word_valid) || $rose(axi_rsp.bvalid); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule
bind unc_ctrl unc_ctrl_asserts unc_ctrl_asserts_inst (
  .core_clk       (core_clk),
  .nrst           (nrst),
  .axi_req        (axi_req),
  .axi_rsp        (axi_rsp),
  .rx_word_valid  (rx_word_valid),
  .rx_err_event   (rx_err_event),
  .tx_word_ready  (tx_word_ready),
  .tx_word_valid  (tx_word_valid),
  .tx_shift_level (tx_shift_level),
  .txd_pin_o      (txd_pin_o),
  .txd_pin_oe     (txd_pin_oe),
  .txd_pin_i      (txd_pin_i),
  .rx_line        (rx_line),
  .irq            (irq)
);

//--- tb/unc_remote.sv
// Remote serial device on the receive line and the shared wire
`timescale 1ns/1ps
module unc_remote (
  input  wire logic txd_pin_o,
  input  wire logic txd_pin_oe,
  input  wire logic drive_en,
  input  wire logic drive_bit,
  output logic      txd_pin_i,
  output logic      rxd_pin_i
);
  // Pull-up holds the shared wire high when released
  assign txd_pin_i = txd_pin_oe ? txd_pin_o : (drive_en ? drive_bit : 1'b1);
  // Talking on the shared wire leaves its own line idle
  assign rxd_pin_i = drive_en ? 1'b1 : drive_bit;
endmodule

//--- tb/unc_ctrl_tb.sv
// Self-checking bench for the ninth-bit, line and error interrupt block
`timescale 1ns/1ps
module unc_ctrl_tb
  import unc_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } unc_row_t;
  logic          core_clk = 1'b0;
  logic          nrst, rx_word_valid, tx_word_ready, tx_word_valid, nine_bit_select, tx_shift_level;
  logic          txd_pin_o, txd_pin_oe, txd_pin_i, rxd_pin_i, rx_line, irq, drive_en, drive_bit;
  logic [8:0]    rx_word, tx_word;
  logic [1:0]    rsp;
  logic [31:0]   rdat;
  unc_err_t      rx_err_event;
  unc_axil_req_t rq;
  unc_axil_rsp_t rs;
  int            n_fail = 0;
  int            n_checks = 0;
  unc_row_t      rows [5] = '{
    '{LINE_ADDR, 32'hFFFF_FF07, 32'h0000_0007, RESP_OKAY},
    '{C3_ADDR, 32'h0000_00FF, 32'h0000_007F, RESP_OKAY},
    '{MASK_ADDR, 32'hFFFF_FF05, 32'h0000_0005, RESP_OKAY},
    '{STAT_ADDR, 32'h0000_000F, 32'h0000_0000, RESP_OKAY},
    '{8'h2C, 32'h0000_00FF, 32'h0000_0000, RESP_SLVERR}};
  always #4 core_clk = ~core_clk;
  unc_ctrl unc_ctrl_inst (
    .core_clk        (core_clk),
    .nrst            (nrst),
    .axi_req         (rq),
    .axi_rsp         (rs),
    .rx_word_valid   (rx_word_valid),
    .rx_word         (rx_word),
    .rx_err_event    (rx_err_event),
    .tx_word_ready   (tx_word_ready),
    .tx_word_valid   (tx_word_valid),
    .tx_word         (tx_word),
    .nine_bit_select (nine_bit_select),
    .tx_shift_level  (tx_shift_level),
    .txd_pin_o       (txd_pin_o),
    .txd_pin_oe      (txd_pin_oe),
    .txd_pin_i       (txd_pin_i),
    .rxd_pin_i       (rxd_pin_i),
    .rx_line         (rx_line),
    .irq             (irq)
  );
  unc_remote unc_remote_inst (
    .txd_pin_o  (txd_pin_o),
    .txd_pin_oe (txd_pin_oe),
    .drive_en   (drive_en),
    .drive_bit  (drive_bit),
    .txd_pin_i  (txd_pin_i),
    .rxd_pin_i  (rxd_pin_i)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One write or one read; ready raised late so the slave must hold
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    rq.awaddr <= a;
    rq.araddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= w;
    rq.wvalid <= w;
    rq.arvalid <= !w;
    for (int k = 0; k < 64; k++) begin
      @(posedge core_clk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
      if (rs.arready) rq.arvalid <= 1'b0;
      if (rs.bvalid && rq.bready || rs.rvalid && rq.rready) begin
        rsp = rs.bvalid ? rs.bresp : rs.rresp;
        rdat = rs.rdata;
        rq.bready <= 1'b0;
        rq.rready <= 1'b0;
        return;
      end
      rq.bready <= rs.bvalid;
      rq.rready <= rs.rvalid;
    end
    n_fail++;
    end_of_test();
  endtask
  task automatic err(input int i);
    rx_err_event <= unc_err_t'(4'(1 << i));
    @(posedge core_clk);
    rx_err_event <= 4'h0;
    @(posedge core_clk);
  endtask
  task automatic txc(input logic [9:0] e);
    chk({tx_word_valid, tx_word}, e);
    tx_word_ready <= 1'b1;
    @(posedge core_clk);
    tx_word_ready <= 1'b0;
    @(posedge core_clk);
    chk(tx_word_valid, 1'b0);
  endtask
  initial begin
    rq = '0;
    nrst = 1'b0;
    {rx_word_valid, tx_word_ready, drive_en, rx_word, rx_err_event} = '0;
    tx_shift_level = 1'b1;
    drive_bit = 1'b1;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      chk(rsp, rows[i].r);
      bus(1'b0, rows[i].a, '0);
      chk(rdat, rows[i].e);
      chk(rsp, rows[i].r);
    end
    $display("register table done");
    nrst <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk({irq, txd_pin_o, txd_pin_oe, rx_line, nine_bit_select, tx_word_valid}, 6'b011100);
    nrst <= 1'b1;
    bus(1'b0, C3_ADDR, '0);
    chk(rdat, 32'h0000_0000);
    bus(1'b0, MASK_ADDR, '0);
    chk(rdat, 32'h0000_000F);
    $display("reset done");
    bus(1'b1, LINE_ADDR, 32'h0000_0001);
    chk(nine_bit_select, 1'b1);
    bus(1'b1, C3_ADDR, 32'h0000_0040);
    bus(1'b1, DATA_ADDR, 32'h0000_00A5);
    repeat (3) @(posedge core_clk);
    txc(10'h3A5);
    bus(1'b1, DATA_ADDR, 32'h0000_003C);
    txc(10'h33C);
    bus(1'b1, LINE_ADDR, 32'h0000_0000);
    bus(1'b1, DATA_ADDR, 32'h0000_003C);
    txc(10'h23C);
    bus(1'b1, LINE_ADDR, 32'h0000_0001);
    rx_word <= 9'h15A;
    rx_word_valid <= 1'b1;
    @(posedge core_clk);
    rx_word_valid <= 1'b0;
    bus(1'b0, C3_ADDR, '0);
    chk(rdat, 32'h0000_00C0);
    bus(1'b0, DATA_ADDR, '0);
    chk(rdat, 32'h0000_005A);
    $display("ninth bit done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, C3_ADDR, '0);
      err(i);
      chk(irq, 1'b0);
      bus(1'b1, C3_ADDR, 32'(1 << i));
      chk(irq, 1'b1);
      bus(1'b1, MASK_ADDR, '0);
      chk(irq, 1'b0);
      bus(1'b1, MASK_ADDR, 32'h0000_000F);
      bus(1'b1, STAT_ADDR, 32'(1 << i));
      chk(irq, 1'b0);
    end
    rx_word <= 9'h011;
    rx_word_valid <= 1'b1;
    @(posedge core_clk);
    rx_word <= 9'h0EE;
    @(posedge core_clk);
    rx_word_valid <= 1'b0;
    bus(1'b0, STAT_ADDR, '0);
    chk(rdat, 32'h0000_0018);
    chk(irq, 1'b1);
    bus(1'b0, DATA_ADDR, '0);
    chk(rdat, 32'h0000_0011);
    bus(1'b1, STAT_ADDR, 32'h0000_0008);
    chk(irq, 1'b0);
    $display("interrupts done");
    drive_bit <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(rx_line, 1'b0);
    drive_bit <= 1'b1;
    bus(1'b1, C3_ADDR, 32'h0000_0010);
    repeat (2) @(posedge core_clk);
    chk(txd_pin_o, 1'b0);
    tx_shift_level <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(txd_pin_o, 1'b1);
    tx_shift_level <= 1'b1;
    bus(1'b1, LINE_ADDR, 32'h0000_0002);
    tx_shift_level <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(rx_line, 1'b0);
    tx_shift_level <= 1'b1;
    bus(1'b1, LINE_ADDR, 32'h0000_0006);
    drive_en <= 1'b1;
    drive_bit <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({txd_pin_oe, rx_line}, 2'b00);
    drive_en <= 1'b0;
    bus(1'b1, C3_ADDR, 32'h0000_0020);
    repeat (2) @(posedge core_clk);
    chk(txd_pin_oe, 1'b1);
    $display("pin tests done");
    end_of_test();
  end
endmodule
